/* File: hdl/moci_cfg.svh */
`ifndef MOCI_CFG_SVH
`define MOCI_CFG_SVH

// register byte offsets
`define MOCI_OFF_CMD      8'h00
`define MOCI_OFF_ARGA     8'h04
`define MOCI_OFF_ARGB     8'h08
`define MOCI_OFF_STATUS   8'h0c
`define MOCI_OFF_RESULT   8'h10
`define MOCI_OFF_FEED     8'h14
`define MOCI_OFF_DEFRAMP  8'h18
`define MOCI_OFF_RATE     8'h1c
`define MOCI_OFF_TPOS     8'h20

// sizes and ranges
`define MOCI_PERSIST_WORDS 100
`define MOCI_PERSIST_MAX   8'h63
`define MOCI_AXES          8
`define MOCI_AXIS_MAX      8'h07
`define MOCI_THREAD_MIN    8'h01
`define MOCI_THREAD_MAX    8'h07
`define MOCI_PHYS_MAX      8'h1e
`define MOCI_VIRT_MIN      8'h20
`define MOCI_VIRT_MAX      8'h3f
`define MOCI_HOLD_MODE_MAX 8'h02

// overrides in signed 16.16 fixed point
`define MOCI_RATE_ONE      32'sh0001_0000
`define MOCI_RATE_MAX      32'sh0064_0000
`define MOCI_RATE_MIN      -32'sh0064_0000
`define MOCI_FEED_RST      32'h0001_0000
`define MOCI_DEFRAMP_RST   32'h0000_0010

// motion buffer wrap
`define MOCI_MAX_SEGMENTS  32'h0000_88b8
`define MOCI_NEAR_MARGIN   32'h0000_0100

// servo sample period
`define MOCI_CLK_NS        4
`define MOCI_SAMPLE_NS     90000
`define MOCI_SAMPLE_CYC    ((`MOCI_SAMPLE_NS) / (`MOCI_CLK_NS))

`endif

/* File: hdl/moci_pkg.sv */
package moci_pkg;

  typedef enum logic [7:0] {
    MOCI_OP_NONE     = 8'h00,
    MOCI_OP_PWRITE   = 8'h01,
    MOCI_OP_PREAD    = 8'h02,
    MOCI_OP_RAPID    = 8'h03,
    MOCI_OP_RAPID_R  = 8'h04,
    MOCI_OP_BOOT     = 8'h05,
    MOCI_OP_BIT      = 8'h06,
    MOCI_OP_BIT_Q    = 8'h07,
    MOCI_OP_GAIN_SET = 8'h08,
    MOCI_OP_GAIN_GET = 8'h09,
    MOCI_OP_SOFT_MIN = 8'h0a,
    MOCI_OP_SOFT_MAX = 8'h0b,
    MOCI_OP_AMP      = 8'h0c,
    MOCI_OP_HOLD     = 8'h0d,
    MOCI_OP_HOLD_Q   = 8'h0e,
    MOCI_OP_BIT_DIR  = 8'h0f
  } moci_op_t;

  typedef enum logic [2:0] {
    MOCI_HS_CLEAR   = 3'b001,
    MOCI_HS_HELD    = 3'b010,
    MOCI_HS_RESUMED = 3'b100
  } moci_hold_t;

  typedef enum logic [1:0] {
    MOCI_MK_BEG_RAPID = 2'h0,
    MOCI_MK_END_RAPID = 2'h1,
    MOCI_MK_BIT_OP    = 2'h2,
    MOCI_MK_OTHER     = 2'h3
  } moci_mkind_t;

  // command word written to the command register
  typedef struct packed {
    logic [7:0] rsvd;
    logic [7:0] mode;
    logic [7:0] idx;
    moci_op_t   op;
  } moci_cmd_t;

  // marker reached by motion buffer execution
  typedef struct packed {
    logic        valid;
    moci_mkind_t kind;
    logic [5:0]  bitNum;
    logic        state;
  } moci_mark_t;

  // bit operation pushed into the motion buffer
  typedef struct packed {
    logic       push;
    logic [5:0] bitNum;
    logic       state;
  } moci_bitq_t;

endpackage

/* File: hdl/motion_override_cmd_interp.sv */
//
// Function
// - keeps one hundred 32-bit user words, reachable by host and user programs.
// - persistent hex write takes offset 0..99 and any 32-bit value, stores it.
// - user words survive restarts once programs are stored to nonvolatile memory.
// - rapid override scales buffer time; 1.0 advances one sample period per period.
// - separate rapid and feed overrides, chosen by rapid begin/end buffer markers.
// - negative rapid override runs the buffer backwards to start or oldest kept.
// - near overwritten data ramp rapid override to zero; at true start halt abruptly.
// - new rapid override is ramped in, default rate from the default ramp register.
// - during feed hold a rapid set only stores the rate resumed after release.
// - rapid override lies within -100..+100; zero stops, negative reverses time.
// - ramped rapid set takes a positive time to ramp override from 0 to 1.
// - boot thread command marks thread 1..7 to launch at power-up or not.
// - bit write drives physical 0..30 (output only) or virtual 32..63 low/high.
// - queued bit write goes into the motion buffer, performed when reached unless a direct bit write lands in that cycle.
// - follower gain set or read for axis 0..7.
// - soft limits block motion like a stop-movement hardware limit.
// - negative limit blocks negative travel, positive limit positive; any sign.
// - microstep nominal amplitude 0..255 per axis.
// - feed hold mode 0 stops, 1 resumes, 2 clears hold state.
// - hold stops any motion kind; hold state readable by query.
`timescale 1ns/10ps
`include "moci_cfg.svh"

module motion_override_cmd_interp #(
  parameter int SAMPLE_CYCLES = `MOCI_SAMPLE_CYC
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // motion buffer side
  input  wire moci_pkg::moci_mark_t mark,
  input  wire logic [31:0]          segWritten,
  input  wire logic [31:0]          curSeg,
  output moci_pkg::moci_bitq_t      bitQueue,
  output logic signed [31:0]        execRate,
  output logic                      rapidSection,
  // axes
  input  wire logic signed [31:0]   axisPos [8],
  input  wire logic [7:0]           axisDirPos,
  input  wire logic [7:0]           axisDirNeg,
  output logic [7:0]                motionBlock,
  output logic [31:0]               followerGain [8],
  output logic [7:0]                microstepLevel [8],
  // io and threads
  output logic [63:0]               ioOut,
  output logic [30:0]               ioDir,
  output logic [7:1]                bootThread
);
  import moci_pkg::*;

  // apb
  logic        apbDone;
  logic        apbWrite;
  logic [31:0] readMux;
  logic        mapped;
  assign apbDone  = psel && penable && pready;
  assign apbWrite = apbDone && pwrite;

  logic [31:0]        argA;
  logic [31:0]        argB;
  logic [31:0]        result;
  logic               errFlag;
  logic signed [31:0] feedRate;
  logic [31:0]        defRamp;
  logic signed [31:0] tpos;
  logic signed [31:0] rapidNow;
  logic signed [31:0] rapidTarget;
  logic [31:0]        rampStep;
  moci_hold_t         holdState;
  logic               holdActive;
  assign holdActive = (holdState == MOCI_HS_HELD);

  // command decode
  moci_cmd_t cmd;
  logic      exec;
  logic      cmdOk;
  assign cmd  = moci_cmd_t'(pwdata);
  assign exec = apbWrite && (paddr == `MOCI_OFF_CMD);

  function automatic logic bitOk(input logic [7:0] n, input logic [30:0] dir);
    bitOk = (n <= `MOCI_PHYS_MAX && dir[n[4:0]]) ||
            (n >= `MOCI_VIRT_MIN && n <= `MOCI_VIRT_MAX);
  endfunction

  function automatic logic rateOk(input logic [31:0] v);
    rateOk = $signed(v) <= `MOCI_RATE_MAX && $signed(v) >= `MOCI_RATE_MIN;
  endfunction

  always_comb begin
    case (cmd.op)
      MOCI_OP_PWRITE, MOCI_OP_PREAD: cmdOk = cmd.idx <= `MOCI_PERSIST_MAX;
      MOCI_OP_RAPID:   cmdOk = rateOk(argA);
      MOCI_OP_RAPID_R: cmdOk = rateOk(argA) && argB != 32'h0;
      MOCI_OP_BOOT:    cmdOk = cmd.idx >= `MOCI_THREAD_MIN && cmd.idx <= `MOCI_THREAD_MAX &&
                               cmd.mode <= 8'h01;
      MOCI_OP_BIT, MOCI_OP_BIT_Q: cmdOk = bitOk(cmd.idx, ioDir) && cmd.mode <= 8'h01;
      MOCI_OP_BIT_DIR: cmdOk = cmd.idx <= `MOCI_PHYS_MAX && cmd.mode <= 8'h01;
      MOCI_OP_GAIN_SET, MOCI_OP_GAIN_GET, MOCI_OP_SOFT_MIN, MOCI_OP_SOFT_MAX:
        cmdOk = cmd.idx <= `MOCI_AXIS_MAX;
      MOCI_OP_AMP:     cmdOk = cmd.idx <= `MOCI_AXIS_MAX && argA <= 32'h0000_00ff;
      MOCI_OP_HOLD:    cmdOk = cmd.mode <= `MOCI_HOLD_MODE_MAX;
      MOCI_OP_HOLD_Q:  cmdOk = 1'b1;
      default:         cmdOk = 1'b0;
    endcase
  end

  logic good;
  assign good = exec && cmdOk;

  // persistent words: no reset, contents are kept across restarts
  logic [31:0] persistMem [`MOCI_PERSIST_WORDS];
  always_ff @(posedge mclk) begin
    if (good && cmd.op == MOCI_OP_PWRITE) begin
      persistMem[cmd.idx[6:0]] <= argA;
    end
  end

  // argument, feed and ramp registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      argA     <= 32'h0;
      argB     <= 32'h0;
      feedRate <= `MOCI_FEED_RST;
      defRamp  <= `MOCI_DEFRAMP_RST;
    end else if (apbWrite) begin
      if (paddr == `MOCI_OFF_ARGA) argA <= pwdata;
      if (paddr == `MOCI_OFF_ARGB) argB <= pwdata;
      if (paddr == `MOCI_OFF_FEED) feedRate <= pwdata;
      if (paddr == `MOCI_OFF_DEFRAMP) defRamp <= pwdata;
    end
  end

  // result and error
  always_ff @(posedge mclk) begin
    if (reset) begin
      result  <= 32'h0;
      errFlag <= 1'b0;
    end else if (exec) begin
      errFlag <= !cmdOk;
      if (cmdOk) begin
        case (cmd.op)
          MOCI_OP_PREAD:    result <= persistMem[cmd.idx[6:0]];
          MOCI_OP_GAIN_GET: result <= followerGain[cmd.idx[2:0]];
          MOCI_OP_HOLD_Q:   result <= {29'h0, holdState};
          default:          result <= result;
        endcase
      end
    end
  end

  // feed hold state
  always_ff @(posedge mclk) begin
    if (reset) begin
      holdState <= MOCI_HS_CLEAR;
    end else if (good && cmd.op == MOCI_OP_HOLD) begin
      case (cmd.mode)
        8'h00:   holdState <= MOCI_HS_HELD;
        8'h01:   holdState <= MOCI_HS_RESUMED;
        8'h02:   holdState <= MOCI_HS_CLEAR;
        default: holdState <= holdState;
      endcase
    end
  end

  // rapid target and ramp step; a set during hold only stores the target and step
  always_ff @(posedge mclk) begin
    if (reset) begin
      rapidTarget <= `MOCI_RATE_ONE;
      rampStep    <= `MOCI_DEFRAMP_RST;
    end else if (good && cmd.op == MOCI_OP_RAPID) begin
      rapidTarget <= argA;
      rampStep    <= defRamp;
    end else if (good && cmd.op == MOCI_OP_RAPID_R) begin
      rapidTarget <= argA;
      rampStep    <= (argB > 32'h0001_0000) ? 32'h1 : 32'h0001_0000 / argB;
    end
  end

  // sample tick
  logic [31:0] tickCnt;
  logic        tick;
  always_ff @(posedge mclk) begin
    if (reset) begin
      tickCnt <= 32'h0;
      tick    <= 1'b0;
    end else begin
      tick    <= (tickCnt == 32'(SAMPLE_CYCLES - 1));
      tickCnt <= (tickCnt == 32'(SAMPLE_CYCLES - 1)) ? 32'h0 : tickCnt + 32'h1;
    end
  end

  // oldest segment still in the wrapped buffer
  logic [31:0] oldestSeg;
  logic        nearOld;
  assign oldestSeg = (segWritten > `MOCI_MAX_SEGMENTS) ? segWritten - `MOCI_MAX_SEGMENTS
                                                       : 32'h0;
  assign nearOld   = (oldestSeg != 32'h0) && (curSeg <= oldestSeg + `MOCI_NEAR_MARGIN);

  // ramp toward goal once per sample; frozen while held
  logic signed [31:0] rampGoal;
  logic signed [31:0] diff;
  assign rampGoal = (nearOld && rapidTarget < 0) ? 32'sh0 : rapidTarget;
  assign diff     = rampGoal - rapidNow;
  always_ff @(posedge mclk) begin
    if (reset) begin
      rapidNow <= `MOCI_RATE_ONE;
    end else if (tick && !holdActive) begin
      if (diff > $signed(rampStep)) begin
        rapidNow <= rapidNow + $signed(rampStep);
      end else if (diff < -$signed(rampStep)) begin
        rapidNow <= rapidNow - $signed(rampStep);
      end else begin
        rapidNow <= rampGoal;
      end
    end
  end

  // rapid section tracking from rapid begin/end markers
  always_ff @(posedge mclk) begin
    if (reset) begin
      rapidSection <= 1'b0;
    end else if (mark.valid && mark.kind == MOCI_MK_BEG_RAPID) begin
      rapidSection <= 1'b1;
    end else if (mark.valid && mark.kind == MOCI_MK_END_RAPID) begin
      rapidSection <= 1'b0;
    end
  end

  // execution rate; time stops hard at the true start of the buffer
  logic signed [31:0] selRate;
  assign selRate = holdActive ? 32'sh0 : (rapidSection ? rapidNow : feedRate);
  always_ff @(posedge mclk) begin
    if (reset) begin
      execRate <= 32'sh0;
    end else if (tpos <= 0 && selRate < 0) begin
      execRate <= 32'sh0;
    end else begin
      execRate <= selRate;
    end
  end

  // buffer time in 16.16 sample periods
  always_ff @(posedge mclk) begin
    if (reset) begin
      tpos <= 32'sh0;
    end else if (tick) begin
      tpos <= (tpos + execRate < 0) ? 32'sh0 : tpos + execRate;
    end
  end

  // io bits, direct or reached in the buffer
  always_ff @(posedge mclk) begin
    if (reset) begin
      ioOut <= 64'h0;
      ioDir <= 31'h0;
    end else begin
      if (good && cmd.op == MOCI_OP_BIT) begin
        ioOut[cmd.idx[5:0]] <= cmd.mode[0];
      end else if (mark.valid && mark.kind == MOCI_MK_BIT_OP &&
                   bitOk({2'b00, mark.bitNum}, ioDir)) begin
        ioOut[mark.bitNum] <= mark.state;
      end
      if (good && cmd.op == MOCI_OP_BIT_DIR) begin
        ioDir[cmd.idx[4:0]] <= cmd.mode[0];
      end
    end
  end

  // queued bit op is only handed to the motion buffer, not applied
  always_ff @(posedge mclk) begin
    if (reset) begin
      bitQueue <= '0;
    end else begin
      bitQueue.push   <= good && cmd.op == MOCI_OP_BIT_Q;
      bitQueue.bitNum <= cmd.idx[5:0];
      bitQueue.state  <= cmd.mode[0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      bootThread <= 7'h0;
    end else if (good && cmd.op == MOCI_OP_BOOT) begin
      bootThread[cmd.idx[2:0]] <= cmd.mode[0];
    end
  end

  // per-axis state and soft limit checks
  logic signed [31:0] softMin [8];
  logic signed [31:0] softMax [8];
  genvar ax;
  generate
    for (ax = 0; ax < `MOCI_AXES; ax++) begin : gAxis
      always_ff @(posedge mclk) begin
        if (reset) begin
          followerGain[ax]   <= 32'h0;
          microstepLevel[ax] <= 8'h0;
          softMin[ax]        <= 32'sh8000_0000;
          softMax[ax]        <= 32'sh7fff_ffff;
          motionBlock[ax]    <= 1'b0;
        end else begin
          if (good && cmd.idx[2:0] == 3'(ax)) begin
            if (cmd.op == MOCI_OP_GAIN_SET) followerGain[ax] <= argA;
            if (cmd.op == MOCI_OP_AMP) microstepLevel[ax] <= argA[7:0];
            if (cmd.op == MOCI_OP_SOFT_MIN) softMin[ax] <= argA;
            if (cmd.op == MOCI_OP_SOFT_MAX) softMax[ax] <= argA;
          end
          // stop-movement behaviour regardless of hardware limit action
          motionBlock[ax] <= (axisDirNeg[ax] && axisPos[ax] <= softMin[ax]) ||
                             (axisDirPos[ax] && axisPos[ax] >= softMax[ax]);
        end
      end
    end
  endgenerate

  // register read mux
  always_comb begin
    mapped  = 1'b1;
    readMux = 32'h0;
    case (paddr)
      `MOCI_OFF_CMD, `MOCI_OFF_ARGA: readMux = (paddr == `MOCI_OFF_ARGA) ? argA : 32'h0;
      `MOCI_OFF_ARGB:    readMux = argB;
      `MOCI_OFF_STATUS:  readMux = {26'h0, rapidSection, nearOld, errFlag, holdState};
      `MOCI_OFF_RESULT:  readMux = result;
      `MOCI_OFF_FEED:    readMux = feedRate;
      `MOCI_OFF_DEFRAMP: readMux = defRamp;
      `MOCI_OFF_RATE:    readMux = execRate;
      `MOCI_OFF_TPOS:    readMux = tpos;
      default:           mapped  = 1'b0;
    endcase
  end

  // one wait state gives every access a fixed two-cycle access phase
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= (psel && penable && !pready && !pwrite) ? readMux : 32'h0;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_apb_wait;
    psel && penable && !pready;
  endsequence
  sequence s_apb_done;
    pready ##1 !pready;
  endsequence
  a_apb_one_wait: assert property (s_apb_wait |=> s_apb_done)
    else $error("apb answer not one cycle after access");
  a_hold_zero_rate: assert property (holdActive |=> execRate == 32'sh0)
    else $error("rate not zero during feed hold");
  a_persist_stored: assert property (good && cmd.op == MOCI_OP_PWRITE |=>
    persistMem[$past(cmd.idx[6:0])] == $past(argA))
    else $error("persistent word not stored");
  a_bad_offset: assert property (exec && cmd.op == MOCI_OP_PWRITE &&
    cmd.idx > `MOCI_PERSIST_MAX |=> errFlag && $stable(result))
    else $error("out of range offset accepted");
  a_hold_keeps_rate: assert property (holdActive && good && cmd.op == MOCI_OP_RAPID |=>
    rapidTarget == $past(argA) && rapidNow == $past(rapidNow))
    else $error("rapid set during hold changed rate");
  a_ramp_moves: assert property (tick && !holdActive && rapidNow != rampGoal |=>
    rapidNow != $past(rapidNow))
    else $error("rapid override did not ramp");
  a_time_floor: assert property (tpos >= 0)
    else $error("buffer time went below start");
  a_rapid_marker: assert property (mark.valid && mark.kind == MOCI_MK_BEG_RAPID &&
    !holdActive ##1 tpos > 0 |-> ##1 execRate == $past(rapidNow))
    else $error("rapid marker did not select rapid rate");
  // axis 2 is the one the tests drive into its limits
  a_soft_block: assert property (axisDirPos[2] && axisPos[2] >= softMax[2] |=>
    motionBlock[2])
    else $error("soft limit did not block motion");
  a_bit_queued: assert property (good && cmd.op == MOCI_OP_BIT_Q && !mark.valid |=>
    bitQueue.push && $stable(ioOut))
    else $error("queued bit applied at once");
  a_virt_bit: assert property (good && cmd.op == MOCI_OP_BIT |=>
    ioOut[$past(cmd.idx[5:0])] == $past(cmd.mode[0]))
    else $error("io bit not written");
endmodule // motion_override_cmd_interp

/* File: sim/moci_host.sv */
`timescale 1ns/10ps
module moci_host (
  // clock
  input  wire logic        mclk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer; request held until pready is seen at an edge, no cycle count assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup never lands in the same step
    @(posedge mclk);
  endtask
endmodule // moci_host

/* File: sim/test_motion_override_cmd_interp.sv */
`timescale 1ns/10ps
`include "moci_cfg.svh"
module test_motion_override_cmd_interp;
  import moci_pkg::*;
  logic               mclk, reset, psel, penable, pwrite, pready, pslverr, e;
  logic               rapidSection;
  logic [7:0]         paddr, axisDirPos, axisDirNeg, motionBlock;
  logic [31:0]        pwdata, prdata, segWritten, curSeg, rdVal, val;
  logic [31:0]        pv [100];
  logic signed [31:0] axisPos [8];
  logic signed [31:0] execRate;
  logic [31:0]        followerGain [8];
  logic [7:0]         microstepLevel [8];
  logic [63:0]        ioOut;
  logic [30:0]        ioDir;
  logic [7:1]         bootThread;
  moci_mark_t         mark;
  moci_bitq_t         bitQueue, lastPush;
  int                 failures, tests_run, pushes, k, ofs;

  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    if (bitQueue.push === 1'b1) begin
      pushes <= pushes + 1;
      lastPush <= bitQueue;
    end
  end

  motion_override_cmd_interp #(.SAMPLE_CYCLES(8)) i_dut (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mark(mark), .segWritten(segWritten), .curSeg(curSeg), .bitQueue(bitQueue),
    .execRate(execRate), .rapidSection(rapidSection), .axisPos(axisPos),
    .axisDirPos(axisDirPos), .axisDirNeg(axisDirNeg), .motionBlock(motionBlock),
    .followerGain(followerGain), .microstepLevel(microstepLevel), .ioOut(ioOut),
    .ioDir(ioDir), .bootThread(bootThread));

  moci_host i_host (
    .mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  function automatic logic [31:0] fx(input int w);
    return 32'(w <<< 16);
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    i_host.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, rdVal, e);
  endtask

  // bad of x skips the error flag compare
  task automatic cmd(input logic [7:0] op, input logic [7:0] idx, input logic [7:0] mode,
                     input logic [31:0] a, input logic bad);
    wr(`MOCI_OFF_ARGA, a);
    wr(`MOCI_OFF_CMD, {8'h00, mode, idx, op});
    rd(`MOCI_OFF_STATUS);
    if (bad !== 1'bx) chk(rdVal[3], bad, "err flag");
  endtask

  task automatic result(input logic [31:0] exp, input string what);
    rd(`MOCI_OFF_RESULT);
    chk(rdVal, exp, what);
  endtask

  task automatic waitRate(input logic [31:0] exp, input int n);
    for (int i = 0; i < n && execRate !== exp; i++) @(posedge mclk);
    chk(execRate, exp, "exec rate");
  endtask

  task automatic mk(input moci_mkind_t kd, input logic [5:0] b, input logic s);
    mark <= '{1'b1, kd, b, s};
    @(posedge mclk);
    mark.valid <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task end_of_test;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    failures++;
    end_of_test;
  end

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    mark = '0;
    segWritten = 32'h0;
    curSeg = 32'h0;
    axisDirPos = 8'h00;
    axisDirNeg = 8'h00;
    axisPos = '{default: 32'sh0};
    failures = 0;
    tests_run = 0;
    pushes = 0;
    k = $urandom(36002);
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(`MOCI_OFF_DEFRAMP);
    chk(rdVal, `MOCI_DEFRAMP_RST, "ramp reset");
    rd(`MOCI_OFF_FEED);
    chk(rdVal, `MOCI_FEED_RST, "feed reset");
    rd(8'h40);
    chk(e, 1'b1, "unmapped");
    // top offset with all ones first, then random words
    for (k = 0; k < 5; k++) begin
      ofs = (k == 0) ? 99 : $urandom_range(98);
      pv[ofs] = (k == 0) ? 32'hffffffff : $urandom;
      cmd(8'h01, 8'(ofs), 8'h00, pv[ofs], 1'b0);
      cmd(8'h02, 8'(ofs), 8'h00, 32'h0, 1'b0);
      result(pv[ofs], "persist");
    end
    cmd(8'h01, 8'd100, 8'h00, 32'h0, 1'b1);
    cmd(8'h02, 8'd99, 8'h00, 32'h0, 1'b0);
    result(32'hffffffff, "persist kept");
    cmd(8'h05, 8'd7, 8'h01, 32'h0, 1'b0);
    chk(bootThread, 7'h40, "boot");
    cmd(8'h05, 8'd0, 8'h01, 32'h0, 1'b1);
    cmd(8'h05, 8'd7, 8'h00, 32'h0, 1'b0);
    chk(bootThread, 7'h00, "boot off");
    cmd(8'h06, 8'd5, 8'h01, 32'h0, 1'b1);
    chk(ioOut[5], 1'b0, "input bit");
    cmd(8'h0f, 8'd30, 8'h01, 32'h0, 1'b0);
    cmd(8'h06, 8'd30, 8'h01, 32'h0, 1'b0);
    chk({ioDir[30], ioOut[30]}, 2'b11, "phys bit");
    cmd(8'h06, 8'd63, 8'h01, 32'h0, 1'b0);
    chk(ioOut[63], 1'b1, "virt bit");
    cmd(8'h06, 8'd31, 8'h01, 32'h0, 1'b1);
    chk(ioOut[31], 1'b0, "gap bit");
    // queued write must not touch the pin until execution reaches it
    cmd(8'h07, 8'd40, 8'h01, 32'h0, 1'b0);
    chk({pushes, lastPush.bitNum, lastPush.state}, {32'd1, 6'd40, 1'b1}, "queue");
    chk(ioOut[40], 1'b0, "not yet");
    mk(MOCI_MK_BIT_OP, 6'd40, 1'b1);
    chk(ioOut[40], 1'b1, "marker bit");
    for (k = 0; k < 3; k++) begin
      ofs = (k == 0) ? 7 : $urandom_range(7);
      val = $urandom;
      cmd(8'h08, 8'(ofs), 8'h00, val, 1'b0);
      chk(followerGain[ofs], val, "gain");
      cmd(8'h09, 8'(ofs), 8'h00, 32'h0, 1'b0);
      result(val, "gain get");
      cmd(8'h0c, 8'(ofs), 8'h00, {24'h0, val[7:0]}, 1'b0);
      chk(microstepLevel[ofs], val[7:0], "amplitude");
    end
    cmd(8'h08, 8'd8, 8'h00, 32'h1, 1'b1);
    // other axes keep the reset range, reached only at the 32-bit extremes
    cmd(8'h0a, 8'd2, 8'h00, -32'sd100, 1'b0);
    cmd(8'h0b, 8'd2, 8'h00, 32'sd500, 1'b0);
    axisPos[2] <= -32'sd100;
    axisPos[0] <= $urandom;
    axisDirNeg <= 8'h04;
    axisDirPos <= 8'h01;
    repeat (3) @(posedge mclk);
    chk(motionBlock, 8'h04, "neg block");
    axisDirNeg <= 8'h00;
    axisDirPos <= 8'h05;
    repeat (3) @(posedge mclk);
    chk(motionBlock, 8'h00, "pos free");
    axisPos[2] <= 32'sd500;
    repeat (3) @(posedge mclk);
    chk(motionBlock, 8'h04, "pos block");
    axisDirPos <= 8'h00;
    wr(`MOCI_OFF_DEFRAMP, 32'h8000);
    mk(MOCI_MK_BEG_RAPID, 6'd0, 1'b0);
    chk(rapidSection, 1'b1, "rapid in");
    wr(`MOCI_OFF_ARGB, 32'h1);
    cmd(8'h04, 8'd0, 8'h00, fx(2), 1'b0);
    waitRate(fx(2), 400);
    rd(`MOCI_OFF_RATE);
    chk(rdVal, fx(2), "rate reg");
    cmd(8'h0d, 8'd0, 8'h00, 32'h0, 1'b0);
    waitRate(32'h0, 400);
    cmd(8'h0e, 8'd0, 8'h00, 32'h0, 1'b0);
    result({29'h0, MOCI_HS_HELD}, "held");
    cmd(8'h03, 8'd0, 8'h00, fx(3), 1'b0);
    repeat (40) @(posedge mclk);
    chk(execRate, 32'h0, "hold keeps");
    cmd(8'h0d, 8'd0, 8'h01, 32'h0, 1'b0);
    waitRate(fx(3), 400);
    cmd(8'h0e, 8'd0, 8'h00, 32'h0, 1'b0);
    result({29'h0, MOCI_HS_RESUMED}, "resumed");
    cmd(8'h0d, 8'd0, 8'h02, 32'h0, 1'b0);
    cmd(8'h0e, 8'd0, 8'h00, 32'h0, 1'b0);
    result({29'h0, MOCI_HS_CLEAR}, "cleared");
    cmd(8'h0d, 8'd0, 8'h03, 32'h0, 1'b1);
    cmd(8'h03, 8'd0, 8'h00, fx(101), 1'b1);
    chk(execRate, fx(3), "rate kept");
    mk(MOCI_MK_END_RAPID, 6'd0, 1'b0);
    waitRate(`MOCI_FEED_RST, 400);
    chk(rapidSection, 1'b0, "rapid out");
    // reverse at the lower bound runs back to the start and halts there
    mk(MOCI_MK_BEG_RAPID, 6'd0, 1'b0);
    // near wrapped-away data the reverse ramp ends at zero, well before the start
    segWritten <= `MOCI_MAX_SEGMENTS + 32'h1000;
    curSeg <= 32'h1100;
    cmd(8'h03, 8'd0, 8'h00, fx(-100), 1'b0);
    chk(rdVal[4], 1'b1, "near old");
    repeat (80) @(posedge mclk);
    chk(execRate, 32'h0, "near ramp stop");
    rd(`MOCI_OFF_TPOS);
    chk(rdVal != 32'h0, 1'b1, "stopped before start");
    segWritten <= 32'h0;
    for (k = 0; k < 2000 && execRate[31] !== 1'b1; k++) @(posedge mclk);
    chk(execRate[31], 1'b1, "reverse");
    waitRate(32'h0, 40000);
    rd(`MOCI_OFF_TPOS);
    chk(rdVal, 32'h0, "at start");
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    cmd(8'h02, 8'd99, 8'h00, 32'h0, 1'b0);
    result(32'hffffffff, "kept over reset");
    chk(execRate, `MOCI_FEED_RST, "rate after reset");
    chk({rapidSection, bootThread}, 8'h00, "state after reset");
    chk(ioOut, 64'h0, "io after reset");
    end_of_test;
  end
endmodule // test_motion_override_cmd_interp
